// ### link_status_readback_regs.sv
// Status readback registers of the link controller on a classic Wishbone slave
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "link_status_consts.svh"

module link_status_readback_regs (
   // Clock and reset
   input  wire logic                          clock_in,
   input  wire logic                          rst_n_in,
   // Wishbone slave
   input  wire logic                          wb_cyc_in,
   input  wire logic                          wb_stb_in,
   input  wire logic                          wb_we_in,
   input  wire logic [5:0]                    wb_adr_in,
   input  wire logic [3:0]                    wb_sel_in,
   input  wire logic [31:0]                   wb_dat_in,
   output logic      [31:0]                   wb_dat_out,
   output logic                               wb_ack_out,
   // Receive side of the device
   input  wire logic                          serial_rx_in,
   input  wire logic                          rx_bit_strobe_in,
   input  wire logic [1:0]                    lssu_segment_index_in,
   input  wire logic                          rx_lookup_cfg_taken_in,
   input  wire logic                          lookup_not_ready_in,
   // Other attention causes and transmit state
   input  wire link_status_pkg::attention_t   attention_in,
   input  wire logic                          tx_attempt_in,
   input  wire logic                          internal_ctrl_flag_in,
   input  wire logic [1:0]                    internal_bits_in,
   // Outputs to the device and the host
   output logic                               rx_mem_setup_go_out,
   output logic                               send_request_n_out,
   output logic                               irq_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and serial input synchroniser

   logic       rst_meta;
   logic       rst_n;
   logic [2:0] rx_sync;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         rx_sync <= 3'h7;
      end else begin
         rx_sync <= {rx_sync[1:0], serial_rx_in};
      end
   end

   // A level counts once the second and third stages agree
   logic rx_level;
   logic next_rx_level;

   always_comb begin
      next_rx_level = rx_level;
      if (rx_sync[1] == rx_sync[2]) begin
         next_rx_level = rx_sync[2];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         rx_level <= 1'b1;
      end else begin
         rx_level <= next_rx_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic bus_req;
   logic bus_wr;
   logic bus_state_is_idle;
   logic bus_state_is_ack;
   logic wr_control;
   logic wr_irq_status;
   logic wr_irq_mask;

   link_status_pkg::bus_state_t bus_state;
   link_status_pkg::bus_state_t next_bus_state;

   assign bus_state_is_idle = (bus_state == link_status_pkg::BUS_IDLE);
   assign bus_state_is_ack  = (bus_state == link_status_pkg::BUS_ACK);
   assign bus_req           = wb_cyc_in && wb_stb_in && bus_state_is_idle;
   // Writes land on the edge at which the master samples ack, while it still holds the request
   assign bus_wr            = wb_cyc_in && wb_stb_in && bus_state_is_ack && wb_we_in && wb_sel_in[0];

   function automatic logic hit(input logic [5:0] adr, input logic [5:0] ofs);
      hit = (adr == ofs);
   endfunction : hit

   assign wr_control        = bus_wr && hit(wb_adr_in, `OFS_CONTROL);
   assign wr_irq_status     = bus_wr && hit(wb_adr_in, `OFS_IRQ_STATUS);
   assign wr_irq_mask       = bus_wr && hit(wb_adr_in, `OFS_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////////
   // Status state

   logic [3:0] ones_count;
   logic [3:0] next_ones_count;
   logic       line_idle;
   logic       next_line_idle;
   logic       setup_ack;
   logic       next_setup_ack;
   logic       setup_request;
   logic       next_setup_request;
   logic       setup_go;
   logic       next_setup_go;
   logic [7:0] attention_reason;
   logic [7:0] next_attention_reason;
   logic       send_request;
   logic       next_send_request;
   logic       attention_code_event;
   logic       idle_rise;
   logic       ack_rise;

   assign attention_code_event = lookup_not_ready_in || attention_in.valid;
   assign idle_rise  = next_line_idle && !line_idle;
   assign ack_rise   = next_setup_ack && !setup_ack;

   always_comb begin
      next_ones_count       = ones_count;
      next_line_idle        = line_idle;
      next_setup_ack        = setup_ack;
      next_setup_request    = setup_request;
      next_attention_reason = attention_reason;
      next_send_request     = tx_attempt_in;
      if (rx_bit_strobe_in) begin
         if (!rx_level) begin
            next_ones_count = 4'h0;
            next_line_idle  = 1'b0;
         end else if (ones_count != `IDLE_ONES_COUNT) begin
            next_ones_count = ones_count + 4'h1;
            if (ones_count + 4'h1 == `IDLE_ONES_COUNT) begin
               next_line_idle = 1'b1;
            end
         end
      end
      if (wr_control) begin
         next_setup_request = wb_dat_in[`BIT_SETUP_REQUEST];
      end
      // Request is only tested while the acknowledge is clear
      if (!setup_ack && setup_request && rx_lookup_cfg_taken_in) begin
         next_setup_ack = 1'b1;
      end
      if (lookup_not_ready_in) begin
         next_setup_ack        = 1'b0;
         next_attention_reason = `CODE_LOOKUP_NOT_READY;
      end else if (attention_in.valid) begin
         next_attention_reason = attention_in.code;
      end
      next_setup_go = next_setup_request && !next_setup_ack;
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         ones_count       <= 4'h0;
         line_idle        <= 1'b0;
         setup_ack        <= 1'b0;
         setup_request    <= 1'b0;
         setup_go         <= 1'b0;
         attention_reason <= `RESET_BYTE;
         send_request     <= 1'b0;
      end else begin
         ones_count       <= next_ones_count;
         line_idle        <= next_line_idle;
         setup_ack        <= next_setup_ack;
         setup_request    <= next_setup_request;
         setup_go         <= next_setup_go;
         attention_reason <= next_attention_reason;
         send_request     <= next_send_request;
      end
   end

   link_status_pkg::status_four_t status_four;

   always_comb begin
      status_four.internal_x7           = internal_bits_in[1];
      status_four.internal_send_request = send_request;
      status_four.line_idle_seen        = line_idle;
      status_four.rx_mem_setup_ack      = setup_ack;
      status_four.internal_x3           = internal_bits_in[0];
      status_four.internal_ctrl_flag    = internal_ctrl_flag_in;
      status_four.lssu_segment_index    = lssu_segment_index_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask

   logic [2:0] irq_status;
   logic [2:0] next_irq_status;
   logic [2:0] irq_mask;
   logic [2:0] next_irq_mask;
   logic [2:0] irq_events;
   logic       next_irq;

   assign irq_events = {ack_rise, idle_rise, attention_code_event};

   always_comb begin
      next_irq_status = irq_status;
      next_irq_mask   = irq_mask;
      if (wr_irq_status) begin
         next_irq_status = irq_status & ~wb_dat_in[2:0];
      end
      if (wr_irq_mask) begin
         next_irq_mask = wb_dat_in[2:0];
      end
      // A new event wins over a clear in the same cycle
      next_irq_status = next_irq_status | irq_events;
      next_irq        = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= `RESET_IRQ;
         irq_mask   <= `RESET_IRQ;
         irq_out    <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_mask   <= next_irq_mask;
         irq_out    <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux and bus answer

   logic [7:0]  read_byte;
   logic [31:0] next_dat;
   logic        next_ack;

   // Reads are side-effect free and the link status and attention reason registers ignore writes
   always_comb begin
      read_byte = 8'h00;
      unique case (wb_adr_in)
         `OFS_LINK_STATUS_FOUR: begin
            read_byte = status_four;
         end
         `OFS_ATTENTION_REASON: begin
            read_byte = attention_reason;
         end
         `OFS_LINK_STATUS_THREE: begin
            read_byte = 8'h00;
            read_byte[`BIT_ATTENTION] = irq_status[`IRQ_ATTENTION];
         end
         `OFS_CONTROL: begin
            read_byte = {7'h00, setup_request};
         end
         `OFS_IRQ_STATUS: begin
            read_byte = {5'h00, irq_status};
         end
         `OFS_IRQ_MASK: begin
            read_byte = {5'h00, irq_mask};
         end
         default: begin
            read_byte = 8'h00;
         end
      endcase
   end

   always_comb begin
      next_bus_state = link_status_pkg::BUS_IDLE;
      next_ack       = 1'b0;
      next_dat       = wb_dat_out;
      if (bus_req) begin
         next_bus_state = link_status_pkg::BUS_ACK;
         next_ack       = 1'b1;
         next_dat       = {24'h000000, read_byte};
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         bus_state          <= link_status_pkg::BUS_IDLE;
         wb_ack_out         <= 1'b0;
         wb_dat_out         <= 32'h00000000;
         rx_mem_setup_go_out <= 1'b0;
         send_request_n_out <= 1'b1;
      end else begin
         bus_state          <= next_bus_state;
         wb_ack_out         <= next_ack;
         wb_dat_out         <= next_dat;
         rx_mem_setup_go_out <= setup_go;
         send_request_n_out <= !next_send_request;
      end
   end

endmodule : link_status_readback_regs

// ### link_status_consts.svh
// Constants: register offsets, field positions, reset values and codes for the status readback block
// Behaviour
// - Bits 1:0 of link_status_four give the next receive link-status segment index.
// - Bit 4 sets once the receive memory configuration from the lookup table is taken.
// - Once acknowledged, the setup request is ignored until reset or a lookup-not-ready event.
// - Bit 5 sets after at least fifteen consecutive ones on the serial input.
// - Any received zero clears bit 5 until another run of fifteen ones.
// - Bit 6 is high whenever the transmitter attempts to send, successful or not.
// - Bit 6 mirrors the active-low request-to-send pin, which is its inverse.
// - attention_reason holds the full eight-bit code of the latest attention cause.
// - Bit 5 of the third status register flags errors or events the host must see.
// - The attention code is c3 when the next receive lookup segment is not ready.
`ifndef LINK_STATUS_CONSTS_SVH
`define LINK_STATUS_CONSTS_SVH

// Byte offsets on the register bus
`define OFS_LINK_STATUS_FOUR  6'h00
`define OFS_ATTENTION_REASON  6'h04
`define OFS_LINK_STATUS_THREE 6'h08
`define OFS_CONTROL           6'h0c
`define OFS_IRQ_STATUS        6'h10
`define OFS_IRQ_MASK          6'h14

// Field positions
`define BIT_SETUP_ACK         4
`define BIT_LINE_IDLE         5
`define BIT_SEND_REQUEST      6
`define BIT_ATTENTION         5
`define BIT_SETUP_REQUEST     0
`define IRQ_ATTENTION         0
`define IRQ_LINE_IDLE         1
`define IRQ_SETUP_ACK         2

// Codes, counts and reset values
`define CODE_LOOKUP_NOT_READY 8'hc3
`define IDLE_ONES_COUNT       4'hf
`define RESET_BYTE            8'h00
`define RESET_IRQ             3'h0

`endif

// ### link_status_pkg.sv
// Package: types shared by the status readback block
package link_status_pkg;

   // Layout of the fourth status register
   typedef struct packed {
      logic       internal_x7;
      logic       internal_send_request;
      logic       line_idle_seen;
      logic       rx_mem_setup_ack;
      logic       internal_x3;
      logic       internal_ctrl_flag;
      logic [1:0] lssu_segment_index;
   } status_four_t;

   // Attention event carried from the device engines
   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } attention_t;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_t;

endpackage : link_status_pkg

// ### link_status_readback_regs_properties.sv
// Checker: bus and status relations at the ports of the status readback block
`timescale 1ns/1ps
`include "link_status_consts.svh"

module link_status_readback_regs_properties (
   input wire logic        clock_in,
   input wire logic        rst_n_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [5:0]  wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic [1:0]  lssu_segment_index_in,
   input wire logic        tx_attempt_in,
   input wire logic        rx_lookup_cfg_taken_in,
   input wire logic        lookup_not_ready_in,
   input wire logic        rx_mem_setup_go_out,
   input wire logic        send_request_n_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_take;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence s_read_four;
      s_take ##0 (!wb_we_in && wb_adr_in == `OFS_LINK_STATUS_FOUR);
   endsequence

   a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   a_ack_after_take: assert property (s_take |=> wb_ack_out)
      else $error("no ack after request");
   a_ack_needs_req: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
      else $error("ack without request");
   a_upper_bytes_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
      else $error("upper read bytes not zero");
   a_segment_index_shown: assert property (
      s_read_four ##0 $stable(lssu_segment_index_in) |=> wb_dat_out[1:0] == $past(lssu_segment_index_in))
      else $error("segment index wrong");
   a_send_follows_tx: assert property ($rose(tx_attempt_in) |=> !send_request_n_out)
      else $error("send request late");
   a_send_bit_mirror: assert property (
      s_read_four ##0 $stable(tx_attempt_in) |=> wb_dat_out[6] == !send_request_n_out)
      else $error("send bit differs from pin");
   a_go_drops_taken: assert property (
      rx_lookup_cfg_taken_in && rx_mem_setup_go_out |-> ##[1:2] !rx_mem_setup_go_out)
      else $error("setup go held after ack");
   a_go_stays_low: assert property (
      $fell(rx_mem_setup_go_out) && !lookup_not_ready_in |=> (!rx_mem_setup_go_out)[*4])
      else $error("setup request retested");
endmodule : link_status_readback_regs_properties

bind link_status_readback_regs link_status_readback_regs_properties chk (.clock_in, .rst_n_in, .wb_cyc_in,
   .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .lssu_segment_index_in, .tx_attempt_in,
   .rx_lookup_cfg_taken_in, .lookup_not_ready_in, .rx_mem_setup_go_out, .send_request_n_out);

// ### link_status_host_model.sv
// Host processor model: classic Wishbone master of the status registers
`timescale 1ns/1ps
`include "link_status_consts.svh"

module link_status_host_model (
   // Clock
   input  wire logic        clock_in,
   // Wishbone master
   output logic             wb_cyc_out,
   output logic             wb_stb_out,
   output logic             wb_we_out,
   output logic [5:0]       wb_adr_out,
   output logic [3:0]       wb_sel_out,
   output logic [31:0]      wb_dat_out,
   input  wire logic [31:0] wb_dat_in,
   input  wire logic        wb_ack_in
);
   initial begin
      wb_cyc_out = 1'b0;
      wb_stb_out = 1'b0;
      wb_we_out  = 1'b0;
      wb_adr_out = 6'h00;
      wb_sel_out = 4'h0;
      wb_dat_out = 32'h0;
   end

   // Entered just after a rising edge; ends one idle cycle after the ack
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q,
                       output bit to);
      to = 1'b1;
      q = 32'h0;
      wb_cyc_out <= 1'b1;
      wb_stb_out <= 1'b1;
      wb_we_out  <= w;
      wb_adr_out <= a;
      wb_sel_out <= 4'h1;
      wb_dat_out <= d;
      for (int i = 0; i < 16 && to; i++) begin
         @(posedge clock_in);
         if (wb_ack_in === 1'b1) begin
            q = wb_dat_in;
            to = 1'b0;
         end
      end
      wb_cyc_out <= 1'b0;
      wb_stb_out <= 1'b0;
      @(posedge clock_in);
   endtask : xfer

   // Waits for the setup acknowledge, then withdraws the setup request
   task automatic release_request(output bit to);
      logic [31:0] q;
      bit          t;
      to = 1'b1;
      for (int i = 0; i < 20 && to; i++) begin
         xfer(1'b0, `OFS_LINK_STATUS_FOUR, 32'h0, q, t);
         if (!t && q[`BIT_SETUP_ACK] === 1'b1) to = 1'b0;
      end
      xfer(1'b1, `OFS_CONTROL, 32'h0, q, t);
      to = to | t;
   endtask : release_request
endmodule : link_status_host_model

// ### link_status_readback_regs_tb.sv
// Testbench: status readback block driven through the host model
`timescale 1ns/1ps
`include "link_status_consts.svh"

module link_status_readback_regs_tb;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic cyc, stb, we, ack, go, snd_n, irq;
   logic ser = 1'b1, strb = 1'b0, taken = 1'b0, lnr = 1'b0, tx = 1'b0;
   logic [5:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [1:0]  idx = 2'h0;
   link_status_pkg::attention_t attention_code = '0;
   int bad_count = 0;
   int n_compared = 0;
   bit to;
   logic [7:0]  codes [8] = '{8'hc1, 8'hc2, 8'h01, 8'h02, 8'h04, 8'h20, 8'h40, 8'h80};

   initial begin
      forever #2 clock_in = ~clock_in;
   end

   link_status_host_model host (.clock_in(clock_in), .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we),
      .wb_adr_out(adr), .wb_sel_out(sel), .wb_dat_out(wdat), .wb_dat_in(rdat), .wb_ack_in(ack));
   link_status_readback_regs dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .serial_rx_in(ser), .rx_bit_strobe_in(strb), .lssu_segment_index_in(idx), .rx_lookup_cfg_taken_in(taken),
      .lookup_not_ready_in(lnr), .attention_in(attention_code), .tx_attempt_in(tx), .internal_ctrl_flag_in(1'b0),
      .internal_bits_in(2'h0), .rx_mem_setup_go_out(go), .send_request_n_out(snd_n), .irq_out(irq));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
      host.xfer(w, a, d, q, to);
      if (to) begin
         bad_count++;
         give_verdict();
      end
   endtask : acc

   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask : tick

   // Strobes n line samples, then reads the idle bit
   task automatic idle_after(input int n, input logic [31:0] exp);
      repeat (n) begin
         strb <= 1'b1;
         tick(1);
         strb <= 1'b0;
         tick(1);
      end
      acc(1'b0, `OFS_LINK_STATUS_FOUR, 32'h0);
      chk(q & 32'h20, exp);
   endtask : idle_after

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(8);
      rst_n_in <= 1'b1;
      tick(3);
      acc(1'b0, `OFS_ATTENTION_REASON, 32'h0);
      chk(q, 32'h0);
      for (int i = 0; i < 4; i++) begin
         idx <= 2'(i);
         tick(2);
         acc(1'b0, `OFS_LINK_STATUS_FOUR, 32'h0);
         chk(q & 32'h3, 32'(i));
      end
      idle_after(14, 32'h0);
      idle_after(1, 32'h20);
      ser <= 1'b0;
      tick(4);
      idle_after(1, 32'h0);
      ser <= 1'b1;
      tick(4);
      idle_after(14, 32'h0);
      idle_after(1, 32'h20);
      tx <= 1'b1;
      tick(2);
      chk(32'(snd_n), 32'h0);
      acc(1'b0, `OFS_LINK_STATUS_FOUR, 32'h0);
      chk(q & 32'h40, 32'h40);
      tx <= 1'b0;
      tick(2);
      chk(32'(snd_n), 32'h1);
      acc(1'b1, `OFS_CONTROL, 32'h1);
      tick(1);
      chk(32'(go), 32'h1);
      taken <= 1'b1;
      tick(1);
      taken <= 1'b0;
      host.release_request(to);
      chk(32'(to), 32'h0);
      acc(1'b1, `OFS_CONTROL, 32'h1);
      tick(2);
      chk(32'(go), 32'h0);
      lnr <= 1'b1;
      tick(1);
      lnr <= 1'b0;
      tick(2);
      chk(32'(go), 32'h1);
      acc(1'b0, `OFS_ATTENTION_REASON, 32'h0);
      chk(q, 32'hc3);
      acc(1'b0, `OFS_LINK_STATUS_THREE, 32'h0);
      chk(q & 32'h20, 32'h20);
      attention_code <= '{1'b1, 8'h40};
      lnr  <= 1'b1;
      tick(1);
      attention_code <= '0;
      lnr  <= 1'b0;
      tick(1);
      acc(1'b0, `OFS_ATTENTION_REASON, 32'h0);
      chk(q, 32'hc3);
      acc(1'b1, `OFS_CONTROL, 32'h0);
      foreach (codes[i]) begin
         attention_code <= '{1'b1, codes[i]};
         tick(1);
         attention_code <= '0;
         tick(1);
         acc(1'b0, `OFS_ATTENTION_REASON, 32'h0);
         chk(q, {24'h0, codes[i]});
      end
      acc(1'b1, `OFS_LINK_STATUS_FOUR, 32'hff);
      acc(1'b1, `OFS_ATTENTION_REASON, 32'h00);
      acc(1'b0, `OFS_ATTENTION_REASON, 32'h0);
      chk(q, 32'h80);
      acc(1'b0, `OFS_LINK_STATUS_FOUR, 32'h0);
      chk(q & 32'h73, 32'h23);
      acc(1'b0, 6'h3c, 32'h0);
      chk(q, 32'h0);
      chk(32'(irq), 32'h0);
      acc(1'b1, `OFS_IRQ_MASK, 32'h1);
      chk(32'(irq), 32'h1);
      acc(1'b1, `OFS_IRQ_STATUS, 32'h7);
      chk(32'(irq), 32'h0);
      acc(1'b0, `OFS_IRQ_STATUS, 32'h0);
      chk(q, 32'h0);
      give_verdict();
   end
endmodule : link_status_readback_regs_tb
